// File: bench/dcdma_asserts.sv
// Port-level assertions for the two-channel transfer engine.
`timescale 1ns/1ps
`default_nettype none
module dcdma_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] en,
   input wire logic [1:0] arm_set,
   input wire logic [1:0] auto_rearm_bit,
   input wire logic [1:0] crc_en,
   input wire logic [1:0] software_request_bit_set,
   input wire logic [1:0] dev_ack,
   input wire logic [1:0] rd_req,
   input wire logic [1:0] rd_gnt,
   input wire logic [1:0] wr_req,
   input wire logic [1:0] wr_gnt,
   input wire logic [1:0] arm_bit,
   input wire logic [1:0] channel_clear_bit,
   input wire logic [1:0] software_request_bit,
   input wire logic [1:0] busy,
   input wire logic [1:0][15:0] pend_cnt,
   input wire logic [1:0] flag_tc,
   input wire logic [1:0] flag_start,
   input wire logic [15:0] crc_value
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   for (genvar c = 0; c < 2; c++) begin : g_ch
      // Bytes read but not yet written; the clear bit flushes the buffer.
      logic [2:0] fill_r;
      always_ff @(posedge mclk) begin
         if (rst || channel_clear_bit[c]) begin
            fill_r <= 3'h0;
         end else begin
            fill_r <= fill_r + 3'(rd_req[c] & rd_gnt[c]) - 3'(wr_req[c] & wr_gnt[c]);
         end
      end
      property p_ack; dev_ack[c] == (wr_req[c] && wr_gnt[c]); endproperty
      a_ack: assert property (p_ack) else $error("ack differs from write grant");
      property p_rd_first; wr_req[c] && wr_gnt[c] |-> fill_r != 3'h0; endproperty
      a_rd_first: assert property (p_rd_first) else $error("write without buffered byte");
      property p_depth; rd_req[c] && rd_gnt[c] |-> fill_r < 3'h4; endproperty
      a_depth: assert property (p_depth) else $error("read into full buffer");
      property p_sw_clr; software_request_bit[c] && !software_request_bit_set[c] |=> !software_request_bit[c]; endproperty
      a_sw_clr: assert property (p_sw_clr) else $error("software request did not self clear");
      property p_sw_dis; software_request_bit_set[c] && !en[c] |=> !software_request_bit[c]; endproperty
      a_sw_dis: assert property (p_sw_dis) else $error("software request taken while disabled");
      property p_dis; !en[c] |=> pend_cnt[c] <= $past(pend_cnt[c]); endproperty
      a_dis: assert property (p_dis) else $error("pending count grew while disabled");
      property p_clr; $past(channel_clear_bit[c]) && channel_clear_bit[c] |-> pend_cnt[c] == 16'h0 && !busy[c]; endproperty
      a_clr: assert property (p_clr) else $error("channel active while cleared");
      property p_rst; disable iff (1'b0) rst |=> channel_clear_bit[c]; endproperty
      a_rst: assert property (p_rst) else $error("reset left clear bit low");
      property p_start; $fell(arm_bit[c]) && $past(!channel_clear_bit[c] && !rst) |-> busy[c] && flag_start[c]; endproperty
      a_start: assert property (p_start) else $error("arm dropped without start");
      property p_idle; !busy[c] && !arm_bit[c] && !auto_rearm_bit[c] && !arm_set[c] |=> !busy[c]; endproperty
      a_idle: assert property (p_idle) else $error("channel started without arming");
      property p_tc; $rose(flag_tc[c]) |-> $past(wr_req[c] && wr_gnt[c]); endproperty
      a_tc: assert property (p_tc) else $error("terminal flag without write");
   end
   property p_crc; $rose(|crc_en) && !(|(rd_req & rd_gnt)) |=> crc_value == 16'h0000; endproperty
   a_crc: assert property (p_crc) else $error("checksum not zeroed on enable");
   c_blk: cover property ($fell(busy[1]));
   c_tc: cover property ($rose(flag_tc[0]));
   c_sat: cover property (pend_cnt[0] == 16'hffff);
endmodule
bind dcdma_top dcdma_asserts u_chk (.mclk, .rst, .en, .arm_set, .auto_rearm_bit, .crc_en,
   .software_request_bit_set, .dev_ack, .rd_req, .rd_gnt, .wr_req, .wr_gnt, .arm_bit,
   .channel_clear_bit, .software_request_bit, .busy, .pend_cnt, .flag_tc, .flag_start, .crc_value);
`default_nettype wire

// File: bench/dcdma_bus_model.sv
// Bus memory model that grants both channels, promptly or with random stalls.
`timescale 1ns/1ps
`default_nettype none
module dcdma_bus_model (
   input wire logic mclk,
   input wire logic slow,
   input wire logic [1:0] rd_req,
   input wire logic [1:0][31:0] rd_addr,
   output logic [1:0] rd_gnt,
   output logic [1:0][7:0] rd_data,
   output logic [1:0] wr_gnt
);
   logic [7:0] lfsr_r = 8'h5b;
   always_ff @(posedge mclk) begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
   end
   assign rd_gnt = slow ? lfsr_r[1:0] : 2'b11;
   assign wr_gnt = slow ? lfsr_r[3:2] : 2'b11;
   // Outside a granted read the data lines carry a moving pattern, lfsr_r with its nibbles swapped.
   for (genvar c = 0; c < 2; c++) begin : g_rd
      assign rd_data[c] = (rd_req[c] && rd_gnt[c]) ? (rd_addr[c][7:0] ^ 8'ha5) : {lfsr_r[3:0], lfsr_r[7:4]};
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the two-channel transfer engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
   import dcdma_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic slow;
   logic [NCH-1:0] en, arm_set, auto_rearm_bit, blk_mode, dir_to_mem, pair, crc_en, dev_req;
   logic [NCH-1:0] channel_clear_bit_wr, channel_clear_bit_wdata, software_request_bit_set;
   logic [NCH-1:0] flag_tc_clr, flag_start_clr, flag_ovf_clr, dev_ack, rd_req, rd_gnt, wr_req, wr_gnt;
   logic [NCH-1:0] arm_bit, channel_clear_bit, software_request_bit, busy, flag_tc, flag_start, flag_ovf;
   logic [NCH-1:0][1:0] addr_mode;
   logic [NCH-1:0][AW-1:0] start_addr, dev_addr, rd_addr, wr_addr, cur_addr;
   logic [NCH-1:0][CW-1:0] start_cnt, cur_cnt;
   logic [NCH-1:0][PW-1:0] pend_cnt;
   logic [NCH-1:0][DW-1:0] rd_data, wr_data;
   logic [CRCW-1:0] crc_value, crc_exp;
   logic [AW-1:0] a;
   logic [AW+DW-1:0] got, exp, exp_q0[$], exp_q1[$];
   int num_errors = 0;
   int compares = 0;
   int acks[2];
   int cyc = 0;
   int n;
   dcdma_top uut (.mclk, .rst, .en, .arm_set, .auto_rearm_bit, .blk_mode, .dir_to_mem, .pair, .crc_en,
      .addr_mode, .start_addr, .start_cnt, .dev_addr, .channel_clear_bit_wr, .channel_clear_bit_wdata,
      .software_request_bit_set, .flag_tc_clr, .flag_start_clr, .flag_ovf_clr, .dev_req, .dev_ack,
      .rd_req, .rd_addr, .rd_gnt, .rd_data, .wr_req, .wr_addr, .wr_data, .wr_gnt, .arm_bit,
      .channel_clear_bit, .software_request_bit, .busy, .cur_addr, .cur_cnt, .pend_cnt, .flag_tc,
      .flag_start, .flag_ovf, .crc_value);
   dcdma_bus_model u_mem (.mclk, .slow, .rd_req, .rd_addr, .rd_gnt, .rd_data, .wr_gnt);
   always #5 mclk = ~mclk;
   task automatic tick(input int k = 1);
      repeat (k) @(negedge mclk);
   endtask
   task automatic stop_test;
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction
   // ***************************************
   // Write monitor: every completed write takes the oldest expected note.
   // ***************************************
   always @(posedge mclk) begin
      for (int c = 0; c < 2; c++) begin
         if (dev_ack[c] === 1'b1) begin
            acks[c]++;
         end
         if (wr_req[c] === 1'b1 && wr_gnt[c] === 1'b1) begin
            got = {wr_addr[c], wr_data[c]};
            exp = 'x;
            if (c == 0 && exp_q0.size() > 0) begin
               exp = exp_q0.pop_front();
            end else if (c == 1 && exp_q1.size() > 0) begin
               exp = exp_q1.pop_front();
            end
            `CHK(got, exp)
         end
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 80000) begin
         num_errors++;
         stop_test;
      end
   end
   initial begin
      void'($urandom(22));
      {en, arm_set, auto_rearm_bit, blk_mode, dir_to_mem, pair, crc_en, dev_req} = '0;
      {channel_clear_bit_wr, channel_clear_bit_wdata, software_request_bit_set} = '0;
      {flag_tc_clr, flag_start_clr, flag_ovf_clr, addr_mode, start_cnt} = '0;
      {start_addr, dev_addr, crc_exp} = '0;
      slow = 1'b0;
      tick(4);
      rst = 1'b0;
      tick;
      `CHK(channel_clear_bit, 2'b11)
      `CHK({busy, flag_tc, flag_start, flag_ovf, pend_cnt}, '0)
      channel_clear_bit_wr = 2'b11;
      tick;
      channel_clear_bit_wr = 2'b00;
      en = 2'b11;
      tick;
      // ***************************************
      // Single mode on channel 0 with held request, stalls and checksum.
      // ***************************************
      n = $urandom_range(5, 2);
      start_cnt[0] = CW'(n - 1);
      start_addr[0] = $urandom;
      dev_addr[0] = $urandom;
      crc_en[0] = 1'b1;
      slow = 1'b1;
      for (int i = 0; i < n; i++) begin
         a = start_addr[0] + AW'(i);
         exp_q0.push_back({dev_addr[0], a[7:0] ^ 8'ha5});
         crc_exp = crc_step(crc_exp, a[7:0] ^ 8'ha5);
      end
      arm_set[0] = 1'b1;
      tick;
      arm_set[0] = 1'b0;
      dev_req[0] = 1'b1;
      tick(n);
      dev_req[0] = 1'b0;
      while (acks[0] < n) tick;
      tick(2);
      `CHK({flag_tc[0], flag_start[0], arm_bit[0], busy[0]}, 4'b1100)
      `CHK({pend_cnt[0], cur_addr[0]}, {16'h0, start_addr[0] + AW'(n)})
      `CHK(crc_value, crc_exp)
      `CHK(acks[0], n)
      {flag_tc_clr[0], flag_start_clr[0]} = 2'b11;
      tick;
      {flag_tc_clr[0], flag_start_clr[0]} = 2'b00;
      tick;
      `CHK({flag_tc[0], flag_start[0]}, 2'b00)
      // ***************************************
      // Block mode on channel 1 by software requests, then a paired copy.
      // ***************************************
      slow = 1'b0;
      {blk_mode[1], dir_to_mem[1], auto_rearm_bit[1]} = 3'b111;
      addr_mode[1] = AM_DEC;
      start_cnt[1] = 24'h000002;
      start_addr[1] = $urandom;
      dev_addr[1] = $urandom;
      for (int i = 0; i < 6; i++) begin
         exp_q1.push_back({start_addr[1] - AW'(i % 3), dev_addr[1][7:0] ^ 8'ha5});
      end
      for (int k = 0; k < 2; k++) begin
         software_request_bit_set[1] = 1'b1;
         tick;
         software_request_bit_set[1] = 1'b0;
         tick;
      end
      while (acks[1] < 6) tick;
      tick(2);
      `CHK({pend_cnt[1], cur_cnt[1], busy[1]}, 41'h0)
      `CHK(crc_value, crc_exp)
      auto_rearm_bit[1] = 1'b0;
      pair = 2'b11;
      for (int i = 0; i < n; i++) begin
         a = start_addr[0] + AW'(i);
         exp_q0.push_back({start_addr[1] - AW'(i), a[7:0] ^ 8'ha5});
      end
      arm_set[0] = 1'b1;
      tick;
      arm_set[0] = 1'b0;
      dev_req[0] = 1'b1;
      tick(n);
      dev_req[0] = 1'b0;
      while (acks[0] < 2 * n) tick;
      tick(2);
      `CHK({cur_addr[1], busy}, {start_addr[1] - AW'(n), 2'b00})
      pair = 2'b00;
      // ***************************************
      // Pending requests, disable, re-enable, saturation and clear.
      // ***************************************
      dev_req[0] = 1'b1;
      tick(3);
      dev_req[0] = 1'b0;
      tick(2);
      `CHK({pend_cnt[0], busy[0]}, {16'h3, 1'b0})
      en[0] = 1'b0;
      tick;
      dev_req[0] = 1'b1;
      software_request_bit_set[0] = 1'b1;
      tick;
      software_request_bit_set[0] = 1'b0;
      tick;
      dev_req[0] = 1'b0;
      tick;
      `CHK(pend_cnt[0], 16'h3)
      en[0] = 1'b1;
      tick(2);
      `CHK(pend_cnt[0], 16'h0)
      dev_req[0] = 1'b1;
      tick(65540);
      dev_req[0] = 1'b0;
      tick;
      `CHK({pend_cnt[0], flag_ovf[0]}, {PEND_MAX, 1'b1})
      flag_ovf_clr[0] = 1'b1;
      tick;
      flag_ovf_clr[0] = 1'b0;
      tick;
      `CHK(flag_ovf[0], 1'b0)
      {channel_clear_bit_wr[0], channel_clear_bit_wdata[0]} = 2'b11;
      tick;
      channel_clear_bit_wr[0] = 1'b0;
      tick(2);
      `CHK({channel_clear_bit[0], pend_cnt[0], cur_addr[0]}, {1'b1, 16'h0, start_addr[0]})
      stop_test;
   end
endmodule
`default_nettype wire

// File: pkg/dcdma_crc_if.sv
// Connection between the channel engines and the shared checksum unit.
`timescale 1ns/1ps
`default_nettype none
interface dcdma_crc_if;
   logic en;
   logic vld;
   logic [7:0] dat;
   logic [15:0] value;
   modport engine (output en, output vld, output dat, input value);
   modport unit (input en, input vld, input dat, output value);
endinterface
`default_nettype wire

// File: pkg/dcdma_pkg.sv
// Constants and types shared by the two-channel transfer engine.
package dcdma_pkg;
   localparam int NCH = 2;
   localparam int AW = 32;
   localparam int DW = 8;
   localparam int CW = 24;
   localparam int PW = 16;
   localparam int FD = 4;
   localparam int FPW = 3;
   localparam int CRCW = 16;
   localparam logic [CRCW-1:0] CRC_POLY = 16'h1021;
   localparam logic [CRCW-1:0] CRC_RST = 16'h0000;
   localparam logic CLR_RST = 1'b1;
   localparam logic ARM_RST = 1'b0;
   localparam logic [PW-1:0] PEND_MAX = 16'hffff;
   localparam logic [FPW-1:0] FIFO_FULL = 3'h4;
   localparam logic [1:0] AM_INC = 2'h0;
   localparam logic [1:0] AM_DEC = 2'h1;
   localparam logic [1:0] AM_FIX = 2'h2;
   typedef enum logic [0:0] {
      DCDMA_IDLE = 1'b0,
      DCDMA_RUN = 1'b1
   } dcdma_state_t;
endpackage

// File: src/dcdma_crc.sv
// Shared 16-bit checksum unit fed by the bytes entering a channel buffer.
`timescale 1ns/1ps
`default_nettype none
module dcdma_crc (
   input wire logic mclk,
   input wire logic rst,
   dcdma_crc_if.unit crc
);
   import dcdma_pkg::*;

   logic en_q_r;
   logic [CRCW-1:0] crc_r;

   function automatic logic [CRCW-1:0] crc_step(input logic [CRCW-1:0] c, input logic [7:0] d);
      logic [CRCW-1:0] v;
      logic fb;
      v = c;
      for (int i = 7; i >= 0; i--) begin
         fb = v[CRCW-1] ^ d[i];
         v = {v[CRCW-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RST);
      end
      return v;
   endfunction

   always_ff @(posedge mclk) begin
      if (rst) begin
         en_q_r <= 1'b0;
      end else begin
         en_q_r <= crc.en;
      end
   end

   // A fresh enable wipes the old result before the first new byte counts.
   always_ff @(posedge mclk) begin
      if (rst) begin
         crc_r <= CRC_RST;
      end else if (crc.en && !en_q_r) begin
         crc_r <= CRC_RST; // RQ22
      end else if (crc.en && crc.vld) begin
         crc_r <= crc_step(crc_r, crc.dat); // RQ23
      end
   end

   assign crc.value = crc_r;
endmodule
`default_nettype wire

// File: src/dcdma_top.sv
// Two-channel byte transfer engine with request pairs and a shared checksum.
// Function
// RQ1 - Two independent channels, each a separate bus master moving one byte per clock.
// RQ2 - An enabled channel accepts requests but serves none until armed; the code also serves an unarmed channel whose auto_rearm_bit is set.
// RQ3 - First request after arming loads counters, clears the arm bit and is served.
// RQ4 - Requests are sampled each cycle; a held request counts once per cycle.
// RQ5 - Unserved requests wait in a pending counter of up to 64K entries.
// RQ6 - With the enable cleared, later requests are ignored everywhere.
// RQ7 - Counters stay readable; clear bit or enabling re-initializes them.
// RQ8 - Clear bit holds the channel in reset; system reset sets it.
// RQ9 - Clear takes one cycle and keeps programmed configuration.
// RQ10 - Block ends at zero count; next block only if armed or continuous.
// RQ11 - Each byte is read into the buffer before it is written.
// RQ12 - Single mode moves one byte per request until the count ends.
// RQ13 - Block mode moves a whole block per request; others wait pending.
// RQ14 - Software request acts as a request, self-clears next cycle, may pend.
// RQ15 - Software request while disabled is ignored.
// RQ16 - Without rearm the channel idles after terminal count until armed again.
// RQ17 - Continuous bit re-arms the channel after each block.
// RQ18 - Software pairs both channels and starts the reading channel for memory copies.
// RQ19 - One address per request, from start address, stepped after use.
// RQ20 - Current address and count of an active block are visible.
// RQ21 - Each channel buffers four bytes between read and write.
// RQ22 - Shared checksum follows the selected channel; enable edge zeroes it.
// RQ23 - Checksum uses x^16+x^12+x^5+1 and is readable afterwards.
// RQ24 - Status flags are sticky; writing one clears, set wins over clear.
// RQ25 - Software programs the count as bytes minus one.
// RQ26 - Each served byte gives a one-cycle acknowledge to the device.
`timescale 1ns/1ps
`default_nettype none
module dcdma_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [dcdma_pkg::NCH-1:0] en,
   input wire logic [dcdma_pkg::NCH-1:0] arm_set,
   input wire logic [dcdma_pkg::NCH-1:0] auto_rearm_bit,
   input wire logic [dcdma_pkg::NCH-1:0] blk_mode,
   input wire logic [dcdma_pkg::NCH-1:0] dir_to_mem,
   input wire logic [dcdma_pkg::NCH-1:0] pair,
   input wire logic [dcdma_pkg::NCH-1:0] crc_en,
   input wire logic [dcdma_pkg::NCH-1:0][1:0] addr_mode,
   input wire logic [dcdma_pkg::NCH-1:0][dcdma_pkg::AW-1:0] start_addr,
   input wire logic [dcdma_pkg::NCH-1:0][dcdma_pkg::CW-1:0] start_cnt,
   input wire logic [dcdma_pkg::NCH-1:0][dcdma_pkg::AW-1:0] dev_addr,
   input wire logic [dcdma_pkg::NCH-1:0] channel_clear_bit_wr,
   input wire logic [dcdma_pkg::NCH-1:0] channel_clear_bit_wdata,
   input wire logic [dcdma_pkg::NCH-1:0] software_request_bit_set,
   input wire logic [dcdma_pkg::NCH-1:0] flag_tc_clr,
   input wire logic [dcdma_pkg::NCH-1:0] flag_start_clr,
   input wire logic [dcdma_pkg::NCH-1:0] flag_ovf_clr,
   input wire logic [dcdma_pkg::NCH-1:0] dev_req,
   output logic [dcdma_pkg::NCH-1:0] dev_ack,
   output logic [dcdma_pkg::NCH-1:0] rd_req,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::AW-1:0] rd_addr,
   input wire logic [dcdma_pkg::NCH-1:0] rd_gnt,
   input wire logic [dcdma_pkg::NCH-1:0][dcdma_pkg::DW-1:0] rd_data,
   output logic [dcdma_pkg::NCH-1:0] wr_req,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::AW-1:0] wr_addr,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::DW-1:0] wr_data,
   input wire logic [dcdma_pkg::NCH-1:0] wr_gnt,
   output logic [dcdma_pkg::NCH-1:0] arm_bit,
   output logic [dcdma_pkg::NCH-1:0] channel_clear_bit,
   output logic [dcdma_pkg::NCH-1:0] software_request_bit,
   output logic [dcdma_pkg::NCH-1:0] busy,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::AW-1:0] cur_addr,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::CW-1:0] cur_cnt,
   output logic [dcdma_pkg::NCH-1:0][dcdma_pkg::PW-1:0] pend_cnt,
   output logic [dcdma_pkg::NCH-1:0] flag_tc,
   output logic [dcdma_pkg::NCH-1:0] flag_start,
   output logic [dcdma_pkg::NCH-1:0] flag_ovf,
   output logic [dcdma_pkg::CRCW-1:0] crc_value
);
   import dcdma_pkg::*;

   // ************************************************************
   // Shared state
   // ************************************************************
   dcdma_state_t st_r [NCH];
   logic [NCH-1:0] clr_r;
   logic [NCH-1:0] en_q_r;
   logic [NCH-1:0] arm_r;
   logic [NCH-1:0] swq_r;
   logic [NCH-1:0] rd_fin_r;
   logic [NCH-1:0] tc_r;
   logic [NCH-1:0] stf_r;
   logic [NCH-1:0] ovf_r;
   logic [PW-1:0] pend_r [NCH];
   logic [AW-1:0] addr_r [NCH];
   logic [CW-1:0] cnt_r [NCH];
   logic [CW-1:0] rdl_r [NCH];
   logic [DW-1:0] fifo_mem [NCH][FD];
   logic [FPW-1:0] wp_r [NCH];
   logic [FPW-1:0] rp_r [NCH];
   logic [NCH-1:0] start;
   logic [NCH-1:0] rd_fire;
   logic [NCH-1:0] wr_fire;
   logic [NCH-1:0] req_ok;
   logic [NCH-1:0] reinit;
   logic paired;

   assign paired = pair[0] & pair[1]; // RQ18

   // ************************************************************
   // Per-channel engine
   // ************************************************************
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic slave;
         logic load;
         logic step;
         logic mem_rd;
         logic dec;
         logic last_wr;
         logic full;
         logic empty;
         logic [FPW-1:0] fill;
         logic [PW-1:0] pend_nxt;

         assign slave = (c == 1) && paired;
         // The fill count has a spare bit, so four stored bytes read as full and not as empty.
         assign fill = wp_r[c] - rp_r[c];
         assign full = (fill == FIFO_FULL); // RQ21
         assign empty = (fill == 3'h0);
         assign mem_rd = !dir_to_mem[c]
            || (c == 0 && paired);

         // A request from the pin or from software counts once per sampled cycle.
         assign req_ok[c] = en[c] && !clr_r[c]
            && (dev_req[c] || swq_r[c]); // RQ4 RQ6

         // Enabling a channel re-initializes its counters, as does the clear bit.
         assign reinit[c] = clr_r[c]
            || (en[c] && !en_q_r[c]); // RQ7

         // Arming or continuous mode is needed before any pending request is served.
         assign start[c] = (st_r[c] == DCDMA_IDLE) && !clr_r[c] && en[c] && !slave
            && (arm_r[c] || auto_rearm_bit[c]) && (pend_r[c] != '0); // RQ2 RQ17 RQ10

         // In single mode each read uses one request; a block uses one for all bytes.
         assign rd_req[c] = (st_r[c] == DCDMA_RUN) && !rd_fin_r[c] && !full
            && (blk_mode[c] || pend_r[c] != '0); // RQ12 RQ13 RQ1
         assign rd_fire[c] = rd_req[c] && rd_gnt[c];
         assign rd_addr[c] = mem_rd ? addr_r[c] : dev_addr[c]; // RQ19

         // The write side only drains bytes already read into the buffer.
         assign wr_req[c] = (st_r[c] == DCDMA_RUN) && !empty; // RQ11
         assign wr_fire[c] = wr_req[c] && wr_gnt[c];
         assign wr_data[c] = fifo_mem[c][rp_r[c][1:0]];
         assign last_wr = wr_fire[c]
            && (cnt_r[c] == '0);
         assign dev_ack[c] = wr_fire[c]; // RQ26

         always_comb begin
            if (c == 0 && paired) begin
               wr_addr[c] = addr_r[1]; // RQ18
            end else if (dir_to_mem[c]) begin
               wr_addr[c] = addr_r[c];
            end else begin
               wr_addr[c] = dev_addr[c];
            end
         end

         assign dec = (start[c] && blk_mode[c])
            || (rd_fire[c] && !blk_mode[c]);

         always_comb begin
            pend_nxt = pend_r[c];
            if (req_ok[c] && !dec && pend_r[c] != PEND_MAX) begin
               pend_nxt = pend_r[c] + 16'h0001; // RQ5 RQ13 RQ14
            end else if (!req_ok[c] && dec) begin
               pend_nxt = pend_r[c] - 16'h0001;
            end
         end

         always_ff @(posedge mclk) begin
            if (rst || reinit[c]) begin
               pend_r[c] <= '0;
            end else begin
               pend_r[c] <= pend_nxt;
            end
         end

         // The clear bit comes up set after system reset; one cycle clears the channel.
         always_ff @(posedge mclk) begin
            if (rst) begin
               clr_r[c] <= CLR_RST; // RQ8
            end else if (channel_clear_bit_wr[c]) begin
               clr_r[c] <= channel_clear_bit_wdata[c]; // RQ8 RQ9
            end
         end

         always_ff @(posedge mclk) begin
            if (rst) begin
               en_q_r[c] <= 1'b0;
            end else begin
               en_q_r[c] <= en[c];
            end
         end

         // Arming set by software wins over the hardware clear in the same cycle.
         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               arm_r[c] <= ARM_RST;
            end else if (arm_set[c]) begin
               arm_r[c] <= 1'b1;
            end else if (start[c]) begin
               arm_r[c] <= 1'b0; // RQ3 RQ16
            end
         end

         // The software request lives one cycle and is dropped while disabled.
         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               swq_r[c] <= 1'b0;
            end else begin
               swq_r[c] <= software_request_bit_set[c]
                  && en[c] && !swq_r[c]; // RQ14 RQ15
            end
         end

         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               st_r[c] <= DCDMA_IDLE;
            end else if (start[c] || (slave && start[0])) begin
               st_r[c] <= slave ? DCDMA_IDLE : DCDMA_RUN; // RQ3
            end else if (last_wr) begin
               st_r[c] <= DCDMA_IDLE; // RQ10 RQ16
            end
         end

         // The slave channel of a pair follows the master's start and writes.
         assign load = start[c] || (slave && start[0])
            || reinit[c];
         assign step = slave ? wr_fire[0]
            : (mem_rd ? rd_fire[c] : wr_fire[c]);

         always_ff @(posedge mclk) begin
            if (rst) begin
               addr_r[c] <= '0;
            end else if (load) begin
               addr_r[c] <= start_addr[c]; // RQ3 RQ19
            end else if (step) begin
               unique case (addr_mode[c])
                  AM_INC: addr_r[c] <= addr_r[c] + 32'h0000_0001; // RQ19
                  AM_DEC: addr_r[c] <= addr_r[c] - 32'h0000_0001;
                  default: addr_r[c] <= addr_r[c];
               endcase
            end
         end

         // Count holds bytes minus one, so zero marks the final byte.
         always_ff @(posedge mclk) begin
            if (rst) begin
               cnt_r[c] <= '0;
            end else if (load) begin
               cnt_r[c] <= start_cnt[c]; // RQ3 RQ25
            end else if (wr_fire[c] && cnt_r[c] != '0) begin
               cnt_r[c] <= cnt_r[c] - 24'h00_0001; // RQ20
            end
         end

         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               rdl_r[c] <= '0;
               rd_fin_r[c] <= 1'b0;
            end else if (start[c]) begin
               rdl_r[c] <= start_cnt[c];
               rd_fin_r[c] <= 1'b0;
            end else if (rd_fire[c]) begin
               rdl_r[c] <= rdl_r[c] - 24'h00_0001;
               rd_fin_r[c] <= (rdl_r[c] == '0);
            end
         end

         // Each channel keeps its own four-byte buffer.
         always_ff @(posedge mclk) begin
            if (rd_fire[c]) begin
               fifo_mem[c][wp_r[c][1:0]] <= rd_data[c]; // RQ11 RQ21
            end
         end

         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               wp_r[c] <= '0;
               rp_r[c] <= '0;
            end else begin
               if (rd_fire[c]) begin
                  wp_r[c] <= wp_r[c] + 3'h1;
               end
               if (wr_fire[c]) begin
                  rp_r[c] <= rp_r[c] + 3'h1;
               end
            end
         end

         // Status flags: a new event in the clearing cycle keeps the flag set.
         always_ff @(posedge mclk) begin
            if (rst || clr_r[c]) begin
               tc_r[c] <= 1'b0;
               stf_r[c] <= 1'b0;
               ovf_r[c] <= 1'b0;
            end else begin
               tc_r[c] <= last_wr || (tc_r[c] && !flag_tc_clr[c]); // RQ24
               stf_r[c] <= start[c] || (stf_r[c] && !flag_start_clr[c]); // RQ24
               ovf_r[c] <= (req_ok[c] && !dec && pend_r[c] == PEND_MAX)
                  || (ovf_r[c] && !flag_ovf_clr[c]); // RQ24 RQ5
            end
         end

         assign arm_bit[c] = arm_r[c];
         assign channel_clear_bit[c] = clr_r[c];
         assign software_request_bit[c] = swq_r[c];
         assign busy[c] = (st_r[c] == DCDMA_RUN);
         assign cur_addr[c] = addr_r[c]; // RQ20
         assign cur_cnt[c] = cnt_r[c]; // RQ20
         assign pend_cnt[c] = pend_r[c]; // RQ7
         assign flag_tc[c] = tc_r[c];
         assign flag_start[c] = stf_r[c];
         assign flag_ovf[c] = ovf_r[c];
      end
   endgenerate

   // ************************************************************
   // Shared checksum
   // ************************************************************
   // Channel 0 takes the unit when both enables are set, since only one stream is covered.
   dcdma_crc_if crc_bus ();

   assign crc_bus.en = crc_en[0] || crc_en[1]; // RQ22
   assign crc_bus.vld = crc_en[0] ? rd_fire[0] : rd_fire[1];
   assign crc_bus.dat = crc_en[0] ? rd_data[0] : rd_data[1];
   assign crc_value = crc_bus.value; // RQ23

   dcdma_crc u_crc (
      .mclk(mclk),
      .rst(rst),
      .crc(crc_bus)
   );
endmodule
`default_nettype wire
